/* File: verilog/dtm_timer.sv */
`timescale 1ns/10ps
module dtm_timer
  import dtm_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [6:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [1:0] EXTERNAL_CLEAR_INPUT,
  output logic [1:0] TIMER_OUTPUT_PIN,
  output logic [1:0] MATCH_A_IRQ,
  output logic [1:0] MATCH_B_IRQ,
  output logic [1:0] OVERFLOW_IRQ,
  output logic TRANSFER_REQ,
  output logic [1:0] VECTOR_INDEX,
  input wire logic TRANSFER_ACK,
  input wire logic TRANSFER_DISABLE_SELECT,
  output logic ADC_START
);
  // ****************************************************************
  // Reset release and register storage
  // ****************************************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;
  dtm_bus_t bus_state_reg;
  logic [7:0] rd_data_reg;
  logic mstop_reg;
  logic [DTM_PS_W-1:0] presc_reg;
  logic [7:0] ctrl_reg [0:1];
  logic [7:0] cora_reg [0:1];
  logic [7:0] corb_reg [0:1];
  logic [7:0] cnt_reg [0:1];
  logic [3:0] os_reg [0:1];
  logic [2:0] flg_reg [0:1];
  logic [2:0] seen_reg [0:1];
  logic [1:0] xcfg_reg;
  logic [1:0] ext_prev_reg;
  logic [1:0] pin_reg;
  logic adc_trigger_enable_reg;
  logic adc_reg;
  logic [7:0] rd_next;
  logic acc;
  logic wr_en;
  logic casc16;
  logic cmcnt;
  wire [1:0] itick;
  wire [1:0] tick;
  wire [1:0] mtick;
  wire [1:0] eqa;
  wire [1:0] eqb;
  wire [1:0] mat_a;
  wire [1:0] mat_b;
  wire [1:0] clr_own;
  wire [1:0] clr;
  wire [1:0] ovf;
  wire [1:0] wr_ctrl;
  wire [1:0] wr_stat;
  wire [1:0] wr_cora;
  wire [1:0] wr_corb;
  wire [1:0] wr_cnt;
  wire [1:0] wr_xcfg;
  wire [3:0] pend;
  wire [3:0] ack_clr;

  // Register address of a channel register
  function automatic logic dtm_hit(input logic [6:0] a, input logic [6:0] ofs,
                                   input int ch);
    dtm_hit = (a == 7'(ofs + ((ch == 1) ? DTM_OFS_STRIDE : 7'h00)));
  endfunction

  // Output action rank equals its code, so the larger action wins
  function automatic logic [1:0] dtm_pick(input logic [1:0] a, input logic [1:0] b);
    dtm_pick = (a > b) ? a : b;
  endfunction

  // Asynchronous assertion, release through two flops
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************************************
  // Avalon slave, one wait state on every access
  // ****************************************************************
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      bus_state_reg <= DTM_IDLE;
    else
    begin
      unique case (bus_state_reg)
        DTM_IDLE: if (AVS_READ | AVS_WRITE) bus_state_reg <= DTM_ACK;
        DTM_ACK: bus_state_reg <= DTM_IDLE;
      endcase
    end
  end

  assign acc = (bus_state_reg == DTM_ACK);
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~acc;
  assign wr_en = AVS_WRITE & acc & AVS_BYTEENABLE[0] & ~mstop_reg;
  assign AVS_READDATA = {24'h000000, rd_data_reg};

  // Read mux; while stopped only the stop control answers
  always_comb
  begin
    rd_next = 8'h00;
    if (AVS_ADDRESS == DTM_OFS_MSTOP)
      rd_next = {7'h00, mstop_reg};
    for (int c = 0; c < DTM_NCH; c++)
    begin
      if (!mstop_reg && dtm_hit(AVS_ADDRESS, DTM_OFS_CTRL, c))
        rd_next = ctrl_reg[c];
      if (!mstop_reg && dtm_hit(AVS_ADDRESS, DTM_OFS_STAT, c))
        rd_next = {flg_reg[c], (c == 0) ? adc_trigger_enable_reg : 1'b0, os_reg[c]};
      if (!mstop_reg && dtm_hit(AVS_ADDRESS, DTM_OFS_CORA, c))
        rd_next = cora_reg[c];
      if (!mstop_reg && dtm_hit(AVS_ADDRESS, DTM_OFS_CORB, c))
        rd_next = corb_reg[c];
      if (!mstop_reg && dtm_hit(AVS_ADDRESS, DTM_OFS_CNT, c))
        rd_next = cnt_reg[c];
      if (!mstop_reg && dtm_hit(AVS_ADDRESS, DTM_OFS_XCFG, c))
        rd_next = {7'h00, xcfg_reg[c]};
    end
  end

  // Read data is caught in the wait cycle and stands at the accept edge
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_reg <= 8'h00;
    else if (AVS_READ && !acc)
      rd_data_reg <= rd_next;
  end

  // Module stop control, the only register open while stopped
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      mstop_reg <= DTM_MSTOP_RST;
    else if (AVS_WRITE && acc && AVS_BYTEENABLE[0] && AVS_ADDRESS == DTM_OFS_MSTOP)
      mstop_reg <= AVS_WRITEDATA[0];
  end

  // Prescaler runs only while the module is enabled
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      presc_reg <= '0;
    else if (!mstop_reg)
      presc_reg <= presc_reg + 1'b1;
  end

  // ****************************************************************
  // Count sources and cascade
  // ****************************************************************
  assign casc16 = (ctrl_reg[0][2:0] == DTM_CKS_CASC) & (ctrl_reg[1][2:0] != DTM_CKS_CASC);
  assign cmcnt = (ctrl_reg[1][2:0] == DTM_CKS_CASC) & (ctrl_reg[0][2:0] != DTM_CKS_CASC);
  // Upper byte steps when the lower byte wraps; both cascade codes stop all
  assign tick[0] = itick[0] | (casc16 & itick[1] & (cnt_reg[1] == 8'hff));
  assign tick[1] = itick[1] | (cmcnt & mat_a[0]);
  assign mtick[0] = casc16 ? itick[1] : tick[0];
  assign mtick[1] = tick[1];
  assign eqa[0] = casc16 ? ({cnt_reg[0], cnt_reg[1]} == {cora_reg[0], cora_reg[1]})
                         : (cnt_reg[0] == cora_reg[0]);
  assign eqb[0] = casc16 ? ({cnt_reg[0], cnt_reg[1]} == {corb_reg[0], corb_reg[1]})
                         : (cnt_reg[0] == corb_reg[0]);
  assign eqa[1] = (cnt_reg[1] == cora_reg[1]);
  assign eqb[1] = (cnt_reg[1] == corb_reg[1]);
  // In 16-bit mode both bytes follow the channel 0 clear only
  assign clr[0] = clr_own[0];
  assign clr[1] = casc16 ? clr_own[0] : clr_own[1];

  // Transfer requests, index 0 (channel 0 match A) has priority
  assign pend = {flg_reg[1][2] & ctrl_reg[1][DTM_CTRL_IEB], flg_reg[1][1] & ctrl_reg[1][DTM_CTRL_IEA],
                 flg_reg[0][2] & ctrl_reg[0][DTM_CTRL_IEB], flg_reg[0][1] & ctrl_reg[0][DTM_CTRL_IEA]};
  assign TRANSFER_REQ = |pend;
  assign VECTOR_INDEX = pend[0] ? 2'h0 : pend[1] ? 2'h1 : pend[2] ? 2'h2 : 2'h3;

  // ****************************************************************
  // Per-channel logic
  // ****************************************************************
  for (genvar ch = 0; ch < DTM_NCH; ch++)
  begin : g_ch
    wire [1:0] cclr = ctrl_reg[ch][4:3];
    wire ext_ev;
    wire [2:0] set_f;
    wire [2:0] clr_f;
    wire [1:0] act;

    dtm_tick_gen dtm_tick_gen_inst (
      .clk(CLK),
      .rst_n(rst_n),
      .stop(mstop_reg),
      .cks(ctrl_reg[ch][2:0]),
      .presc(presc_reg),
      .tick(itick[ch])
    );

    // Bus write strobes at the accept edge
    assign wr_ctrl[ch] = wr_en & dtm_hit(AVS_ADDRESS, DTM_OFS_CTRL, ch);
    assign wr_stat[ch] = wr_en & dtm_hit(AVS_ADDRESS, DTM_OFS_STAT, ch);
    assign wr_cora[ch] = wr_en & dtm_hit(AVS_ADDRESS, DTM_OFS_CORA, ch);
    assign wr_corb[ch] = wr_en & dtm_hit(AVS_ADDRESS, DTM_OFS_CORB, ch);
    assign wr_cnt[ch] = wr_en & dtm_hit(AVS_ADDRESS, DTM_OFS_CNT, ch);
    assign wr_xcfg[ch] = wr_en & dtm_hit(AVS_ADDRESS, DTM_OFS_XCFG, ch);

    // Match on the tick that leaves the equal value
    assign mat_a[ch] = mtick[ch] & eqa[ch] & ~wr_cora[ch];
    assign mat_b[ch] = mtick[ch] & eqb[ch] & ~wr_corb[ch];
    // Level mode clears every cycle the input is high, edge mode once
    assign ext_ev = xcfg_reg[ch] ? EXTERNAL_CLEAR_INPUT[ch]
                                 : EXTERNAL_CLEAR_INPUT[ch] & ~ext_prev_reg[ch];
    assign clr_own[ch] = ((cclr == DTM_CCLR_A) & mat_a[ch]) | ((cclr == DTM_CCLR_B) & mat_b[ch])
                       | ((cclr == DTM_CCLR_EXT) & ext_ev);
    assign ovf[ch] = tick[ch] & (cnt_reg[ch] == 8'hff) & ~clr[ch] & ~wr_cnt[ch];
    assign ack_clr[2*ch] = TRANSFER_ACK & ~TRANSFER_DISABLE_SELECT & (VECTOR_INDEX == 2'(2*ch));
    assign ack_clr[2*ch+1] = TRANSFER_ACK & ~TRANSFER_DISABLE_SELECT
                           & (VECTOR_INDEX == 2'(2*ch+1));
    assign set_f = {mat_b[ch], mat_a[ch], ovf[ch]};
    assign clr_f = ({3{wr_stat[ch]}} & ~AVS_WRITEDATA[7:5] & seen_reg[ch])
                 | {ack_clr[2*ch+1], ack_clr[2*ch], 1'b0};
    assign act = dtm_pick(mat_a[ch] ? os_reg[ch][1:0] : DTM_OS_NOP,
                          mat_b[ch] ? os_reg[ch][3:2] : DTM_OS_NOP);

    // Control, compare and option registers
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ctrl_reg[ch] <= DTM_CTRL_RST;
        cora_reg[ch] <= DTM_COR_RST;
        corb_reg[ch] <= DTM_COR_RST;
        os_reg[ch] <= 4'h0;
        xcfg_reg[ch] <= 1'b0;
      end
      else
      begin
        if (wr_ctrl[ch])
          ctrl_reg[ch] <= AVS_WRITEDATA[7:0];
        if (wr_cora[ch])
          cora_reg[ch] <= AVS_WRITEDATA[7:0];
        if (wr_corb[ch])
          corb_reg[ch] <= AVS_WRITEDATA[7:0];
        if (wr_stat[ch])
          os_reg[ch] <= AVS_WRITEDATA[3:0];
        if (wr_xcfg[ch])
          xcfg_reg[ch] <= AVS_WRITEDATA[0];
      end
    end

    // Counter: clear, then write, then count
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
        cnt_reg[ch] <= DTM_CNT_RST;
      else if (clr[ch])
        cnt_reg[ch] <= 8'h00;
      else if (wr_cnt[ch])
        cnt_reg[ch] <= AVS_WRITEDATA[7:0];
      else if (tick[ch])
        cnt_reg[ch] <= cnt_reg[ch] + 8'h01;
    end

    // Sticky flags, a new event beats a clear in the same cycle
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
        flg_reg[ch] <= 3'h0;
      else
        flg_reg[ch] <= set_f | (flg_reg[ch] & ~clr_f);
    end

    // Remember flags seen as 1 by a read; a write of 0 only clears those
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
        seen_reg[ch] <= 3'h0;
      else if (wr_stat[ch])
        seen_reg[ch] <= 3'h0;
      else if (AVS_READ && acc && !mstop_reg && dtm_hit(AVS_ADDRESS, DTM_OFS_STAT, ch))
        seen_reg[ch] <= seen_reg[ch] | rd_data_reg[7:5];
    end

    // Output pin and external clear history
    always_ff @(posedge CLK or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pin_reg[ch] <= 1'b0;
        ext_prev_reg[ch] <= 1'b0;
      end
      else
      begin
        ext_prev_reg[ch] <= EXTERNAL_CLEAR_INPUT[ch];
        unique case (act)
          DTM_OS_NOP: pin_reg[ch] <= pin_reg[ch];
          DTM_OS_LOW: pin_reg[ch] <= 1'b0;
          DTM_OS_HIGH: pin_reg[ch] <= 1'b1;
          DTM_OS_TOG: pin_reg[ch] <= ~pin_reg[ch];
        endcase
      end
    end

    // Interrupt requests stay up until the flag is cleared
    assign MATCH_A_IRQ[ch] = flg_reg[ch][1] & ctrl_reg[ch][DTM_CTRL_IEA];
    assign MATCH_B_IRQ[ch] = flg_reg[ch][2] & ctrl_reg[ch][DTM_CTRL_IEB];
    assign OVERFLOW_IRQ[ch] = flg_reg[ch][0] & ctrl_reg[ch][DTM_CTRL_OVIE];
  end

  assign TIMER_OUTPUT_PIN = pin_reg;

  // A/D trigger, a one-cycle pulse after channel 0 match A
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adc_trigger_enable_reg <= 1'b0;
      adc_reg <= 1'b0;
    end
    else
    begin
      if (wr_stat[0])
        adc_trigger_enable_reg <= AVS_WRITEDATA[DTM_STAT_ADC_TRIGGER_ENABLE];
      adc_reg <= adc_trigger_enable_reg & mat_a[0];
    end
  end
  assign ADC_START = adc_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_wrap1;
    tick[1] && cnt_reg[1] == 8'hff && !clr[1] && !wr_cnt[1];
  endsequence
  sequence s_tog_a0;
    mat_a[0] && !mat_b[0] && os_reg[0][1:0] == DTM_OS_TOG;
  endsequence

  property p_flag_timing;
    $rose(flg_reg[0][1]) |-> $past(mtick[0]) && $past(eqa[0]);
  endproperty
  a_flag_timing: assert property (p_flag_timing) else $error("match A flag off tick");
  property p_toggle;
    s_tog_a0 |=> TIMER_OUTPUT_PIN[0] != $past(TIMER_OUTPUT_PIN[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");
  property p_clr;
    clr[0] |=> cnt_reg[0] == 8'h00 && flg_reg[0][0] == $past(flg_reg[0][0]);
  endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_ovf;
    s_wrap1 |=> flg_reg[1][0] && cnt_reg[1] == 8'h00;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");
  property p_wr_cnt;
    wr_cnt[1] && !clr[1] |=> cnt_reg[1] == $past(AVS_WRITEDATA[7:0]);
  endproperty
  a_wr_cnt: assert property (p_wr_cnt) else $error("write lost to count");
  property p_both_casc;
    ctrl_reg[0][2:0] == DTM_CKS_CASC && ctrl_reg[1][2:0] == DTM_CKS_CASC |-> tick == 2'b00;
  endproperty
  a_both_casc: assert property (p_both_casc) else $error("counting in dual cascade");
  property p_stop;
    mstop_reg |=> $stable(cnt_reg[0]) && $stable(cnt_reg[1]);
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped");
  property p_adc;
    adc_trigger_enable_reg && mat_a[0] |=> ADC_START ##1 !ADC_START;
  endproperty
  a_adc: assert property (p_adc) else $error("A/D start not one pulse");
  property p_cmcnt;
    cmcnt && mat_a[0] && !clr[1] && !wr_cnt[1] |=> cnt_reg[1] == 8'($past(cnt_reg[1]) + 8'h01);
  endproperty
  a_cmcnt: assert property (p_cmcnt) else $error("match count missed");
  property p_bus;
    (AVS_READ || AVS_WRITE) && !acc |=> !AVS_WAITREQUEST;
  endproperty
  a_bus: assert property (p_bus) else $error("no answer after one wait");
endmodule

/* File: verilog/dtm_pkg.sv */
package dtm_pkg;
  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int DTM_NCH = 2;
  localparam int DTM_PS_W = 6;
  localparam int DTM_PS_D2 = 0;
  localparam int DTM_PS_D8 = 2;
  localparam int DTM_PS_D64 = 5;
  // ****************************************************************
  // Register byte offsets, channel 1 sits one stride above channel 0
  // ****************************************************************
  localparam logic [6:0] DTM_OFS_CTRL = 7'h00;
  localparam logic [6:0] DTM_OFS_STAT = 7'h04;
  localparam logic [6:0] DTM_OFS_CORA = 7'h08;
  localparam logic [6:0] DTM_OFS_CORB = 7'h0c;
  localparam logic [6:0] DTM_OFS_CNT = 7'h10;
  localparam logic [6:0] DTM_OFS_XCFG = 7'h14;
  localparam logic [6:0] DTM_OFS_STRIDE = 7'h20;
  localparam logic [6:0] DTM_OFS_MSTOP = 7'h40;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DTM_CTRL_IEB = 7;
  localparam int DTM_CTRL_IEA = 6;
  localparam int DTM_CTRL_OVIE = 5;
  localparam int DTM_CTRL_CCLR = 3;
  localparam int DTM_CTRL_CKS = 0;
  localparam int DTM_STAT_FLG = 5;
  localparam int DTM_STAT_ADC_TRIGGER_ENABLE = 4;
  localparam int DTM_STAT_OS = 0;
  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [2:0] DTM_CKS_D2 = 3'h1;
  localparam logic [2:0] DTM_CKS_D8 = 3'h2;
  localparam logic [2:0] DTM_CKS_D64 = 3'h3;
  localparam logic [2:0] DTM_CKS_CASC = 3'h4;
  localparam logic [1:0] DTM_CCLR_A = 2'h1;
  localparam logic [1:0] DTM_CCLR_B = 2'h2;
  localparam logic [1:0] DTM_CCLR_EXT = 2'h3;
  localparam logic [1:0] DTM_OS_NOP = 2'h0;
  localparam logic [1:0] DTM_OS_LOW = 2'h1;
  localparam logic [1:0] DTM_OS_HIGH = 2'h2;
  localparam logic [1:0] DTM_OS_TOG = 2'h3;
  localparam logic [7:0] DTM_CTRL_RST = 8'h00;
  localparam logic [7:0] DTM_COR_RST = 8'hff;
  localparam logic [7:0] DTM_CNT_RST = 8'h00;
  localparam logic DTM_MSTOP_RST = 1'b1;
  typedef enum logic [1:0] {DTM_IDLE = 2'b01, DTM_ACK = 2'b10} dtm_bus_t;
endpackage

/* File: verilog/dtm_tick_gen.sv */
`timescale 1ns/10ps
// Count tick from the selected prescaler tap, falling edge of its level
module dtm_tick_gen
  import dtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stop,
  input wire logic [2:0] cks,
  input wire logic [DTM_PS_W-1:0] presc,
  output logic tick
);
  logic lvl;
  logic lvl_reg;

  // Codes without an internal source read as a steady low level
  always_comb
  begin
    unique case (cks)
      DTM_CKS_D2: lvl = presc[DTM_PS_D2];
      DTM_CKS_D8: lvl = presc[DTM_PS_D8];
      DTM_CKS_D64: lvl = presc[DTM_PS_D64];
      default: lvl = 1'b0;
    endcase
  end

  // The edge is watched all the time, so a source switch that drops
  // the level also counts once; this is intended behaviour
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lvl_reg <= 1'b0;
    else
      lvl_reg <= lvl;
  end

  assign tick = ~stop & lvl_reg & ~lvl;
endmodule

/* File: dv/dtm_xfer_model.sv */
`timescale 1ns/10ps
// ****************************************************************
// Transfer controller stand-in
// ****************************************************************
module dtm_xfer_model
  import dtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [1:0] index,
  input wire logic [3:0] delay,
  output logic ack,
  output logic dis_sel,
  output logic [7:0] acks,
  output logic [1:0] last_index
);
  // One ack pulse per request; the extra edge lets the request drop first
  initial
  begin
    ack = 1'b0;
    dis_sel = 1'b0;
    acks = 8'h00;
    last_index = 2'h0;
    forever
    begin
      @(negedge clk);
      if (rst_n === 1'b1 && req === 1'b1)
      begin
        repeat (delay) @(posedge clk);
        @(posedge clk);
        ack <= 1'b1;
        @(negedge clk);
        last_index = index;
        @(posedge clk);
        ack <= 1'b0;
        acks <= acks + 8'h01;
        @(posedge clk);
      end
    end
  end
endmodule

/* File: dv/dtm_timer_tb.sv */
`timescale 1ns/10ps
module dtm_timer_tb
  import dtm_pkg::*;
;
  logic CLK, RST_B, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, ADC_START;
  logic TRANSFER_REQ, TRANSFER_ACK, TRANSFER_DISABLE_SELECT;
  logic [6:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [3:0] AVS_BYTEENABLE, delay;
  logic [1:0] EXTERNAL_CLEAR_INPUT, TIMER_OUTPUT_PIN, MATCH_A_IRQ, MATCH_B_IRQ;
  logic [1:0] OVERFLOW_IRQ, VECTOR_INDEX, last_idx;
  logic [7:0] acks, rd;
  int mismatches, comparisons, adc_pulses, n;
  localparam logic [6:0] S = DTM_OFS_STRIDE;
  dtm_timer dtm_timer_inst (.CLK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .EXTERNAL_CLEAR_INPUT, .TIMER_OUTPUT_PIN, .MATCH_A_IRQ, .MATCH_B_IRQ,
    .OVERFLOW_IRQ, .TRANSFER_REQ, .VECTOR_INDEX, .TRANSFER_ACK,
    .TRANSFER_DISABLE_SELECT, .ADC_START);
  dtm_xfer_model dtm_xfer_model_inst (.clk(CLK), .rst_n(RST_B), .req(TRANSFER_REQ),
    .index(VECTOR_INDEX), .delay(delay), .ack(TRANSFER_ACK),
    .dis_sel(TRANSFER_DISABLE_SELECT), .acks(acks), .last_index(last_idx));
  // ****************************************************************
  // Bench plumbing
  // ****************************************************************
  // Free running clock
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // Count A/D start pulses on settled values
  always @(negedge CLK)
    if (ADC_START === 1'b1) adc_pulses++;
  task end_sim;
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waitrequest is combinational, so it is taken at the negedge before the edge
  task bus(input logic w, input logic [6:0] a, input logic [7:0] d);
    logic wq;
    int k;
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h0, d};
    k = 0;
    do
    begin
      @(negedge CLK);
      wq = AVS_WAITREQUEST;
      rd = AVS_READDATA[7:0];
      k++;
      @(posedge CLK);
    end while (wq !== 1'b0 && k < 20);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (wq !== 1'b0)
    begin
      mismatches++;
      end_sim;
    end
    @(posedge CLK);
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rdchk(input string nm, input logic [6:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rd);
  endtask
  // Bounded wait for pin 0, request or overflow irq 1 to reach a level
  task wait_lvl(input int w, input logic l, output int c);
    logic s;
    c = 0;
    do
    begin
      @(negedge CLK);
      s = (w == 0) ? TIMER_OUTPUT_PIN[0] : (w == 1) ? TRANSFER_REQ : OVERFLOW_IRQ[1];
      c++;
    end while (s !== l && c < 2000);
    if (s !== l)
    begin
      mismatches++;
      end_sim;
    end
    @(posedge CLK);
  endtask
  task pulse_clear;
    EXTERNAL_CLEAR_INPUT <= 2'h1;
    repeat (2) @(posedge CLK);
    EXTERNAL_CLEAR_INPUT <= 2'h0;
    @(posedge CLK);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_stop;
    rdchk("mstop", DTM_OFS_MSTOP, 8'h01);
    wr(DTM_OFS_CORA, 8'h12);
    wr(DTM_OFS_MSTOP, 8'h00);
    rdchk("cora", DTM_OFS_CORA, DTM_COR_RST);
    rdchk("unmapped", 7'h7c, 8'h00);
    chk("pin", 8'h00, {6'h0, TIMER_OUTPUT_PIN});
  endtask
  // Toggle on A, clear on A at 3, CLK/2: (3 + 1) ticks of 2 cycles between toggles
  task t_match;
    wr(DTM_OFS_CORA, 8'h03);
    wr(DTM_OFS_STAT, 8'h13);
    wr(DTM_OFS_CTRL, 8'h09);
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    chk("period", 8'h08, n[7:0]);
    wr(DTM_OFS_CTRL, 8'h00);
    rdchk("stat0", DTM_OFS_STAT, 8'h53);
    chk("adc", 8'h01, {7'h0, adc_pulses > 0});
    wr(DTM_OFS_STAT, 8'h13);
    rdchk("stat0 clr", DTM_OFS_STAT, 8'h13);
  endtask
  // Channel 1 wraps through ff, which also matches both reset compares
  task t_ovf;
    wr(DTM_OFS_CNT + S, 8'hfd);
    wr(DTM_OFS_CTRL + S, 8'h21);
    wait_lvl(2, 1'b1, n);
    chk("irqa1", 8'h00, {7'h0, MATCH_A_IRQ[1]});
    chk("irqb1", 8'h00, {7'h0, MATCH_B_IRQ[1]});
    wr(DTM_OFS_CTRL + S, 8'h00);
    rdchk("stat1", DTM_OFS_STAT + S, 8'he0);
  endtask
  task t_xfer;
    delay <= 4'h3;
    wr(DTM_OFS_CNT, 8'h00);
    wr(DTM_OFS_CORA, 8'h10);
    wr(DTM_OFS_CTRL, 8'h41);
    wait_lvl(1, 1'b1, n);
    chk("index", 8'h00, {6'h0, VECTOR_INDEX});
    wait_lvl(1, 1'b0, n);
    chk("acks", 8'h01, acks);
    chk("last index", 8'h00, {6'h0, last_idx});
    wr(DTM_OFS_CTRL, 8'h00);
    rdchk("stat0 xfer", DTM_OFS_STAT, 8'h13);
  endtask
  // Level clear only acts when the clear select asks for it; edge mode clears once
  task t_clear;
    wr(DTM_OFS_XCFG, 8'h01);
    wr(DTM_OFS_CNT, 8'h40);
    pulse_clear;
    rdchk("no clear", DTM_OFS_CNT, 8'h40);
    wr(DTM_OFS_CTRL, 8'h18);
    pulse_clear;
    rdchk("ext clear", DTM_OFS_CNT, 8'h00);
    wr(DTM_OFS_XCFG, 8'h00);
    wr(DTM_OFS_CNT, 8'h40);
    pulse_clear;
    rdchk("edge clear", DTM_OFS_CNT, 8'h00);
  endtask
  // Low byte wraps into the high byte, then channel 1 counts channel 0 matches
  task t_casc;
    wr(DTM_OFS_STAT + S, 8'h02);
    wr(DTM_OFS_CNT + S, 8'hfe);
    wr(DTM_OFS_CNT, 8'h00);
    wr(DTM_OFS_CTRL, {5'h00, DTM_CKS_CASC});
    wr(DTM_OFS_CTRL + S, 8'h01);
    repeat (20) @(posedge CLK);
    wr(DTM_OFS_CTRL + S, 8'h00);
    rdchk("cnt16 hi", DTM_OFS_CNT, 8'h01);
    chk("pin1", 8'h01, {7'h0, TIMER_OUTPUT_PIN[1]});
    wr(DTM_OFS_CORA, 8'h01);
    wr(DTM_OFS_CTRL, 8'h09);
    wr(DTM_OFS_CNT + S, 8'h00);
    wr(DTM_OFS_CTRL + S, {5'h00, DTM_CKS_CASC});
    repeat (20) @(posedge CLK);
    wr(DTM_OFS_CTRL, 8'h00);
    bus(1'b0, DTM_OFS_CNT + S, 8'h00);
    chk("match count", 8'h01, {7'h0, rd > 8'h03});
  endtask
  task t_both;
    wr(DTM_OFS_CTRL, {5'h00, DTM_CKS_CASC});
    wr(DTM_OFS_CTRL + S, {5'h00, DTM_CKS_CASC});
    wr(DTM_OFS_CNT, 8'h05);
    wr(DTM_OFS_CNT + S, 8'h05);
    repeat (40) @(posedge CLK);
    rdchk("cnt0", DTM_OFS_CNT, 8'h05);
    rdchk("cnt1", DTM_OFS_CNT + S, 8'h05);
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    RST_B = 1'b0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 7'h00;
    AVS_WRITEDATA = 32'h0;
    AVS_BYTEENABLE = 4'h1;
    EXTERNAL_CLEAR_INPUT = 2'h0;
    delay = 4'h0;
    mismatches = 0;
    comparisons = 0;
    adc_pulses = 0;
    repeat (3) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK);
    t_stop;
    t_match;
    t_ovf;
    t_xfer;
    t_clear;
    t_casc;
    t_both;
    end_sim;
  end
endmodule
